// File: common/swp_defs.svh
// Purpose: Timing counts and widths shared by both ends of the single wire link.
// Assumes: System clock of 100 ns, bench link clock of 160 ns.
// Notes: Least times round up to whole cycles, longest times round down.
`ifndef SWP_DEFS_SVH
`define SWP_DEFS_SVH

`define SWP_SYS_NS 100
`define SWP_LINK_NS 160
`define SWP_BYTE_W 8
`define SWP_FIFO_D 8
`define SWP_CNT_W 8

// Nominal bit period sent by the front_end_master, inside the default band.
`define SWP_BIT_NS 2000
`define SWP_BIT_CYC (`SWP_BIT_NS / `SWP_SYS_NS)
// High time of a one is three quarters of the period, of a zero one quarter.
`define SWP_ONE_HIGH_CYC ((`SWP_BIT_CYC * 3) / 4)
`define SWP_ZERO_HIGH_CYC (`SWP_BIT_CYC / 4)

// Extended band that the card_slave accepts for every bit.
`define SWP_T_MIN_NS 590
`define SWP_T_MAX_NS 10000
`define SWP_T_MIN_CYC ((`SWP_T_MIN_NS + `SWP_LINK_NS - 1) / `SWP_LINK_NS)
`define SWP_T_MAX_CYC (`SWP_T_MAX_NS / `SWP_LINK_NS)

`define SWP_IDLE_BYTE 8'h00

`endif

// File: common/swp_pkg.sv
// Purpose: Types shared by both ends of the single wire link.
// Assumes: Timing counts live in swp_defs.svh.
// Notes: State codes step in Gray order along the usual path.
package swp_pkg;

    typedef logic [7:0] swp_byte_t;
    typedef logic [7:0] swp_cnt_t;

    // Transmit phase of the master.
    typedef enum logic [1:0] {
        SWP_PH_OFF = 2'b00,
        SWP_PH_RUN = 2'b01
    } swp_phase_e;

    // Link state as seen by the slave decoder.
    typedef enum logic [1:0] {
        SWP_LK_OFF  = 2'b00,
        SWP_LK_RUN  = 2'b01,
        SWP_LK_SUSP = 2'b11
    } swp_link_e;

endpackage

// File: common/swp_if.sv
// Purpose: The single_wire_contact joining the master and the slave.
// Assumes: S1 is a voltage driven by the master, S2 a current load switched by the slave.
// Notes: An undriven contact resolves low here.
`timescale 1ns/1ps
interface swp_if;
    logic s1_drv;
    logic s1_oe;
    logic s2_load;
    logic s1_line;

    // Resolved S1 level; high impedance reads as low.
    assign s1_line = s1_oe & s1_drv;

    modport master (output s1_drv, output s1_oe, input s2_load);
    modport slave (input s1_line, output s2_load);
endinterface

// File: design/swp_master.sv
// Purpose: front_end_master end: duty-cycle coder on S1 and S2 current sampler.
// Assumes: S1 is made from SYS_CLK_I by a divider; the line is byte aligned from enable.
// Notes: Idle time is filled with whole zero bytes so the stream never pauses.
`timescale 1ns/1ps
`include "swp_defs.svh"
module swp_master (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    swp_if.master link,
    input wire logic DISABLE_I,
    input wire logic [7:0] TX_DATA_I,
    input wire logic TX_VALID_I,
    output logic TX_READY_O,
    output logic [7:0] RX_DATA_O,
    output logic RX_VALID_O
);
    swp_pkg::swp_phase_e ph_q, ph_d;
    swp_pkg::swp_cnt_t cyc_q, cyc_d, hi_q, hi_d;
    swp_pkg::swp_byte_t sh_q, sh_d, hold_q, hold_d, rxs_q, rxs_d, rxd_q, rxd_d;
    logic [2:0] cnt_q, cnt_d, rxc_q, rxc_d;
    logic hold_v_q, hold_v_d, rdy_q, rdy_d, rxv_q, rxv_d, arm_q, arm_d;
    logic s1_q, s1_d, oe_q, oe_d, s2_m_q, s2_s_q;
    logic start;
    swp_pkg::swp_byte_t nbyte;

    // Next state of coder, byte holder and sampler.
    always_comb begin
        ph_d = ph_q;
        cyc_d = cyc_q;
        hi_d = hi_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        hold_d = hold_q;
        hold_v_d = hold_v_q;
        rxs_d = rxs_q;
        rxc_d = rxc_q;
        rxd_d = rxd_q;
        rxv_d = 1'b0;
        arm_d = arm_q;
        nbyte = hold_v_q ? hold_q : `SWP_IDLE_BYTE;
        if (TX_VALID_I && rdy_q) begin
            hold_d = TX_DATA_I;
            hold_v_d = 1'b1;
        end
        // RL1: hold contact released.
        if (DISABLE_I) begin
            ph_d = swp_pkg::SWP_PH_OFF;
            arm_d = 1'b0;
            start = 1'b0;
            // Both counters restart so the next enable is byte aligned again.
            cnt_d = 3'h0;
            rxc_d = 3'h0;
        end else begin
            ph_d = swp_pkg::SWP_PH_RUN;
            start = (ph_q == swp_pkg::SWP_PH_OFF) || (cyc_q == 8'(`SWP_BIT_CYC - 1));
        end
        // RL5: bits back to back.
        if (start) begin
            cyc_d = 8'h00;
            // RL12: MSB goes first.
            if (cnt_q != 3'h0) begin
                hi_d = sh_q[7] ? 8'(`SWP_ONE_HIGH_CYC) : 8'(`SWP_ZERO_HIGH_CYC);
                sh_d = {sh_q[6:0], 1'b0};
                cnt_d = cnt_q - 3'h1;
            end else begin
                // RL3: one is long high.
                // RL4: zero is short high.
                hi_d = nbyte[7] ? 8'(`SWP_ONE_HIGH_CYC) : 8'(`SWP_ZERO_HIGH_CYC);
                sh_d = {nbyte[6:0], 1'b0};
                cnt_d = 3'h7;
                if (hold_v_q) begin
                    hold_v_d = 1'b0;
                end
            end
            if (ph_q == swp_pkg::SWP_PH_RUN) begin
                arm_d = 1'b1;
            end
        end else if (ph_q == swp_pkg::SWP_PH_RUN) begin
            cyc_d = cyc_q + 8'h01;
        end
        // RL2: sample S2 while high.
        // RL9: load read as level.
        if (ph_d == swp_pkg::SWP_PH_RUN && arm_q && cyc_q == hi_q - 8'h01) begin
            rxs_d = {rxs_q[6:0], s2_s_q};
            rxc_d = rxc_q + 3'h1;
            if (rxc_q == 3'h7) begin
                rxd_d = {rxs_q[6:0], s2_s_q};
                rxv_d = 1'b1;
            end
        end
        rdy_d = ~hold_v_d;
        // RL8: fixed period in band.
        s1_d = (ph_d == swp_pkg::SWP_PH_RUN) && (cyc_d < hi_d);
        oe_d = (ph_d == swp_pkg::SWP_PH_RUN);
    end

    // Registers; the S2 sense is asynchronous, so it passes two flops first.
    always_ff @(posedge SYS_CLK_I) begin
        s2_m_q <= link.s2_load;
        s2_s_q <= s2_m_q;
        if (RST_I) begin
            ph_q <= swp_pkg::SWP_PH_OFF;
            cyc_q <= 8'h00;
            hi_q <= 8'h00;
            sh_q <= 8'h00;
            cnt_q <= 3'h0;
            hold_q <= 8'h00;
            hold_v_q <= 1'b0;
            rdy_q <= 1'b0;
            rxs_q <= 8'h00;
            rxc_q <= 3'h0;
            rxd_q <= 8'h00;
            rxv_q <= 1'b0;
            arm_q <= 1'b0;
            s1_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            ph_q <= ph_d;
            cyc_q <= cyc_d;
            hi_q <= hi_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            hold_q <= hold_d;
            hold_v_q <= hold_v_d;
            rdy_q <= rdy_d;
            rxs_q <= rxs_d;
            rxc_q <= rxc_d;
            rxd_q <= rxd_d;
            rxv_q <= rxv_d;
            arm_q <= arm_d;
            s1_q <= s1_d;
            oe_q <= oe_d;
        end
    end

    assign link.s1_drv = s1_q;
    assign link.s1_oe = oe_q;
    assign TX_READY_O = rdy_q;
    assign RX_DATA_O = rxd_q;
    assign RX_VALID_O = rxv_q;
endmodule // swp_master

// File: design/swp_slave.sv
// Purpose: card_slave end: S1 edge-interval decoder and S2 current-load return path.
// Assumes: LINK_CLK_I oversamples S1; SYS_CLK_I runs the user side.
// Notes: Bytes are cut every eight bits from link start; framing sits above this block.
// Functional notes
// RL1: Master releases contact after unsupported card.
// RL2: S2 valid only while S1 high.
// RL3: One: S1 high 0.70 to 0.80.
// RL4: Zero: S1 high 0.20 to 0.30.
// RL5: Master sends bits with no gaps.
// RL6: Bit spans rising edge to rising edge.
// RL7: Classify each bit from own interval.
// RL8: Period 0.590 to 10 us handled.
// RL9: S2 high draws current, low draws none.
// RL10: Return data only by S2 load.
// RL11: S2 switches only while S1 low.
// RL12: Bits travel most significant first.
// RL13: High time over half period means one.
`timescale 1ns/1ps
`include "swp_defs.svh"
module swp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem_q [D];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [AW:0] cnt_q, cnt_d;
    logic push, pop;

    // Pointers wrap naturally, so D must be a power of two.
    always_comb begin
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        wr_d = push ? wr_q + AW'(1) : wr_q;
        rd_d = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    assign in_ready_o = (cnt_q != (AW+1)'(D));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o = mem_q[rd_q];

    // Storage and pointers.
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
        if (rst_i) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule // swp_fifo

module swp_slave (
    input wire logic SYS_CLK_I,
    input wire logic LINK_CLK_I,
    input wire logic RST_I,
    swp_if.slave link,
    output logic [7:0] RX_DATA_O,
    output logic RX_VALID_O,
    input wire logic RX_READY_I,
    output logic RX_OVERRUN_O,
    input wire logic [7:0] TX_DATA_I,
    input wire logic TX_VALID_I,
    output logic TX_READY_O
);
    // Link domain.
    logic lrst_m_q, lrst_q, s1_m_q, s1_s_q, s1_p_q;
    swp_pkg::swp_link_e lst_q, lst_d;
    swp_pkg::swp_cnt_t per_q, per_d, hi_q, hi_d;
    swp_pkg::swp_byte_t rxs_q, rxs_d, rxb_q, rxb_d, tsh_q, tsh_d;
    logic [2:0] rxc_q, rxc_d, txc_q, txc_d;
    logic rxt_q, rxt_d, tack_q, tack_d, s2_q, s2_d, treq_m_q, treq_s_q;
    logic rise, fall, bitv;
    // System domain.
    logic rxt_m_q, rxt_s_q, rxt_p_q, tack_m_q, tack_s_q;
    logic treq_q, treq_d, rdy_q, rdy_d, ovr_q, ovr_d, ov_q, ov_d;
    swp_pkg::swp_byte_t thold_q, thold_d, od_q, od_d, f_data;
    logic push, f_in_ready, f_out_valid, pop, accept;

    // Decoder and S2 driver on the oversampling clock.
    always_comb begin
        rise = s1_s_q && !s1_p_q;
        fall = !s1_s_q && s1_p_q;
        lst_d = lst_q;
        per_d = (per_q == 8'hFF) ? per_q : per_q + 8'h01;
        hi_d = (s1_s_q && hi_q != 8'hFF) ? hi_q + 8'h01 : hi_q;
        rxs_d = rxs_q;
        rxc_d = rxc_q;
        rxb_d = rxb_q;
        rxt_d = rxt_q;
        tsh_d = tsh_q;
        txc_d = txc_q;
        tack_d = tack_q;
        s2_d = s2_q;
        // RL13: high against half period.
        bitv = ({hi_q, 1'b0} > {1'b0, per_q});
        case (lst_q)
            swp_pkg::SWP_LK_OFF, swp_pkg::SWP_LK_SUSP: begin
                if (rise) begin
                    lst_d = swp_pkg::SWP_LK_RUN;
                    per_d = 8'h01;
                    hi_d = 8'h01;
                    rxc_d = 3'h0;
                    txc_d = 3'h0;
                end
            end
            swp_pkg::SWP_LK_RUN: begin
                // RL6: rise closes and opens.
                if (rise) begin
                    // RL7: own interval per bit.
                    // RL12: shift in MSB first.
                    rxs_d = {rxs_q[6:0], bitv};
                    rxc_d = rxc_q + 3'h1;
                    if (rxc_q == 3'h7) begin
                        rxb_d = {rxs_q[6:0], bitv};
                        rxt_d = ~rxt_q;
                    end
                    per_d = 8'h01;
                    hi_d = 8'h01;
                // RL8: beyond longest period.
                end else if (per_q > 8'(`SWP_T_MAX_CYC + 1)) begin // Slack so edge jitter keeps a 10 us bit alive.
                    lst_d = s1_s_q ? swp_pkg::SWP_LK_SUSP : swp_pkg::SWP_LK_OFF;
                    if (!s1_s_q) begin
                        s2_d = 1'b0;
                    end
                end
                // RL11: switch on falling edge.
                if (fall) begin
                    // RL10: data only by load.
                    if (txc_q != 3'h0) begin
                        s2_d = tsh_q[7];
                        tsh_d = {tsh_q[6:0], 1'b0};
                        txc_d = txc_q - 3'h1;
                    end else begin
                        txc_d = 3'h7;
                        if (treq_s_q != tack_q) begin
                            s2_d = thold_q[7];
                            tsh_d = {thold_q[6:0], 1'b0};
                            tack_d = ~tack_q;
                        end else begin
                            s2_d = 1'b0;
                            tsh_d = `SWP_IDLE_BYTE;
                        end
                    end
                end
            end
            default: begin
                lst_d = swp_pkg::SWP_LK_OFF;
            end
        endcase
    end

    // Link registers; S1, reset and request toggle each pass two flops.
    always_ff @(posedge LINK_CLK_I) begin
        lrst_m_q <= RST_I;
        lrst_q <= lrst_m_q;
        s1_m_q <= link.s1_line;
        s1_s_q <= s1_m_q;
        s1_p_q <= s1_s_q;
        treq_m_q <= treq_q;
        treq_s_q <= treq_m_q;
        if (lrst_q) begin
            lst_q <= swp_pkg::SWP_LK_OFF;
            per_q <= 8'h00;
            hi_q <= 8'h00;
            rxs_q <= 8'h00;
            rxc_q <= 3'h0;
            rxb_q <= 8'h00;
            rxt_q <= 1'b0;
            tsh_q <= 8'h00;
            txc_q <= 3'h0;
            tack_q <= 1'b0;
            s2_q <= 1'b0;
        end else begin
            lst_q <= lst_d;
            per_q <= per_d;
            hi_q <= hi_d;
            rxs_q <= rxs_d;
            rxc_q <= rxc_d;
            rxb_q <= rxb_d;
            rxt_q <= rxt_d;
            tsh_q <= tsh_d;
            txc_q <= txc_d;
            tack_q <= tack_d;
            s2_q <= s2_d;
        end
    end

    // RL2: load meaningful while high.
    // RL9: load on means S2 high.
    assign link.s2_load = s2_q;

    // Byte toggle edge pushes into the FIFO; the byte itself is stable for several bits.
    always_comb begin
        push = rxt_s_q ^ rxt_p_q;
        ovr_d = ovr_q || (push && !f_in_ready);
        pop = f_out_valid && (!ov_q || RX_READY_I);
        ov_d = pop ? 1'b1 : (RX_READY_I ? 1'b0 : ov_q);
        od_d = pop ? f_data : od_q;
        accept = TX_VALID_I && rdy_q;
        treq_d = treq_q ^ accept;
        thold_d = accept ? TX_DATA_I : thold_q;
        rdy_d = (treq_d == tack_s_q);
    end

    swp_fifo #(
        .W(`SWP_BYTE_W),
        .D(`SWP_FIFO_D)
    ) u_fifo (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .in_valid_i(push),
        .in_ready_o(f_in_ready),
        .in_data_i(rxb_q),
        .out_valid_o(f_out_valid),
        .out_ready_i(!ov_q || RX_READY_I),
        .out_data_o(f_data)
    );

    // System registers.
    always_ff @(posedge SYS_CLK_I) begin
        rxt_m_q <= rxt_q;
        rxt_s_q <= rxt_m_q;
        tack_m_q <= tack_q;
        tack_s_q <= tack_m_q;
        if (RST_I) begin
            rxt_p_q <= 1'b0;
            ovr_q <= 1'b0;
            ov_q <= 1'b0;
            od_q <= 8'h00;
            treq_q <= 1'b0;
            thold_q <= 8'h00;
            rdy_q <= 1'b0;
        end else begin
            rxt_p_q <= rxt_s_q;
            ovr_q <= ovr_d;
            ov_q <= ov_d;
            od_q <= od_d;
            treq_q <= treq_d;
            thold_q <= thold_d;
            rdy_q <= rdy_d;
        end
    end

    assign RX_DATA_O = od_q;
    assign RX_VALID_O = ov_q;
    assign RX_OVERRUN_O = ovr_q;
    assign TX_READY_O = rdy_q;
endmodule // swp_slave

// File: verification/swp_props.sv
// Purpose: Watches the single_wire_contact between both ends.
// Assumes: Master bit period and high times from swp_defs.svh.
// Notes: Runs are counted in helper flops because they outgrow short repetitions.
`timescale 1ns/1ps
`include "swp_defs.svh"
module swp_props (
    input wire logic SYS_CLK_I,
    input wire logic LINK_CLK_I,
    input wire logic RST_I,
    input wire logic s1_drv,
    input wire logic s1_oe,
    input wire logic s2_load,
    input wire logic s1_line
);
    localparam int BIT = `SWP_BIT_CYC;
    localparam int ONE_HI = `SWP_ONE_HIGH_CYC;
    localparam int ZERO_HI = `SWP_ZERO_HIGH_CYC;
    logic [7:0] hi_q;
    logic [7:0] per_q;
    logic run_q;
    logic [7:0] low_q;

    // High run, cycles since the last rise, and whether a whole bit was seen.
    always_ff @(posedge SYS_CLK_I) begin
        if (RST_I) begin
            hi_q <= 8'h00;
            per_q <= 8'h00;
            run_q <= 1'b0;
        end else begin
            hi_q <= s1_line ? hi_q + 8'h01 : 8'h00;
            per_q <= $rose(s1_line) ? 8'h01 : per_q + {7'h00, per_q != 8'hFF};
            run_q <= s1_oe && (run_q || $rose(s1_line));
        end
    end

    // Low run in link cycles; the slave must give up the load once S1 rests low.
    always_ff @(posedge LINK_CLK_I) begin
        low_q <= (s1_line || RST_I) ? 8'h00 : low_q + {7'h00, low_q != 8'hFF};
    end

    a_high_time_legal: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $fell(s1_line) && s1_oe |-> hi_q == ONE_HI || hi_q == ZERO_HI) else $error("S1 high time wrong");
    a_high_run_cap: assert property (@(posedge SYS_CLK_I) disable iff (RST_I) hi_q <= ONE_HI)
        else $error("S1 high too long");
    a_high_run_min: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(s1_line) |-> (s1_line || !s1_oe)[*5]) else $error("S1 high too short");
    a_bit_period_fixed: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $rose(s1_line) && run_q |-> per_q == BIT) else $error("Bit period wrong");
    a_one_low_gap: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $fell(s1_line) && s1_oe && hi_q == ONE_HI |-> (!s1_line)[*5] ##1 (s1_line || !s1_oe))
        else $error("Gap after one");
    a_zero_low_gap: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        $fell(s1_line) && s1_oe && hi_q == ZERO_HI |-> (!s1_line)[*8] ##8 (s1_line || !s1_oe))
        else $error("Gap after zero");
    a_s2_switch_low: assert property (@(posedge LINK_CLK_I) disable iff (RST_I)
        $changed(s2_load) |-> !$past(s1_line)) else $error("S2 switched while S1 high");
    a_s2_idle_off: assert property (@(posedge LINK_CLK_I) disable iff (RST_I)
        low_q > 8'h46 |-> !s2_load) else $error("S2 load while link off");
    a_release_drv_low: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
        !s1_oe |-> !s1_drv) else $error("S1 level driven while released");

    c_one_bit: cover property (@(posedge SYS_CLK_I) $fell(s1_line) && hi_q == ONE_HI);
    c_zero_bit: cover property (@(posedge SYS_CLK_I) $fell(s1_line) && hi_q == ZERO_HI);
    c_s2_rise: cover property (@(posedge LINK_CLK_I) $rose(s2_load));
    c_release: cover property (@(posedge SYS_CLK_I) $fell(s1_oe));
endmodule // swp_props

// File: verification/tb.sv
// Purpose: Joins master and slave on one contact and checks bytes both ways.
// Assumes: Idle bytes are 8'h00, so payload bytes are never zero.
// Notes: Overrun and drain run last since overrun only clears on reset.
`timescale 1ns/1ps
`include "swp_defs.svh"
`define TB_CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_fail++; \
    $display("[FAIL] t=%0t got %0h exp %0h", $time, a, b); end end
module tb;
    localparam int N = 12;
    logic clk = 1'b0;
    logic lclk = 1'b0;
    logic rst = 1'b1;
    logic dis = 1'b0;
    logic [7:0] m_txd = 8'h00, s_txd = 8'h00, m_rxd, s_rxd, hi = 8'h00, sh = 8'h00;
    logic m_txv = 1'b0, s_txv = 1'b0, s_rxr = 1'b0, seen = 1'b0;
    logic m_txr, m_rxv, s_rxv, s_ovr, s_txr;
    logic [1:0] mode = 2'h0; // Ready: 0 random, 1 stalled, 2 always.
    logic [7:0] exp_s[$], exp_m[$], got_s[$], got_m[$];
    int n_fail = 0, tests_run = 0, pops = 0, p0 = 0;

    // System clock, and a link clock free running with its own phase.
    initial begin forever #50 clk = ~clk; end
    initial begin #37; forever #80 lclk = ~lclk; end

    swp_if swp_if_i ();
    swp_master swp_master_i (.SYS_CLK_I(clk), .RST_I(rst), .link(swp_if_i), .DISABLE_I(dis),
        .TX_DATA_I(m_txd), .TX_VALID_I(m_txv), .TX_READY_O(m_txr), .RX_DATA_O(m_rxd), .RX_VALID_O(m_rxv));
    swp_slave swp_slave_i (.SYS_CLK_I(clk), .LINK_CLK_I(lclk), .RST_I(rst), .link(swp_if_i),
        .RX_DATA_O(s_rxd), .RX_VALID_O(s_rxv), .RX_READY_I(s_rxr), .RX_OVERRUN_O(s_ovr),
        .TX_DATA_I(s_txd), .TX_VALID_I(s_txv), .TX_READY_O(s_txr));
    swp_props swp_props_i (.SYS_CLK_I(clk), .LINK_CLK_I(lclk), .RST_I(rst), .s1_drv(swp_if_i.s1_drv),
        .s1_oe(swp_if_i.s1_oe), .s2_load(swp_if_i.s2_load), .s1_line(swp_if_i.s1_line));

    // Corner bytes first, then random nonzero ones.
    function automatic logic [7:0] pick(input int i);
        logic [7:0] t [4] = '{8'hFF, 8'h80, 8'h01, 8'hC1};
        return (i < 4) ? t[i] : 8'(($urandom % 255) + 1);
    endfunction
    function automatic logic [7:0] hi_exp(input logic b);
        return b ? 8'(`SWP_ONE_HIGH_CYC) : 8'(`SWP_ZERO_HIGH_CYC);
    endfunction

    // Byte hand-offs hold valid until ready is seen, then leave one edge free.
    task automatic m_send(input logic [7:0] b);
        m_txd <= b;
        m_txv <= 1'b1;
        do @(posedge clk); while (m_txr !== 1'b1);
        m_txv <= 1'b0;
        @(posedge clk);
    endtask
    task automatic s_send(input logic [7:0] b);
        s_txd <= b;
        s_txv <= 1'b1;
        do @(posedge clk); while (s_txr !== 1'b1);
        s_txv <= 1'b0;
        @(posedge clk);
    endtask

    // Slave ready drive and collection of received payload on both user sides.
    always @(posedge clk) begin
        s_rxr <= (mode == 2'h2) || (mode == 2'h0 && $urandom % 2 == 1);
        if (s_rxv === 1'b1 && s_rxr === 1'b1) pops++;
        if (s_rxv === 1'b1 && s_rxr === 1'b1 && s_rxd !== 8'h00) got_s.push_back(s_rxd);
        if (m_rxv === 1'b1 && m_rxd !== 8'h00) got_m.push_back(m_rxd);
    end

    // Decodes S1 from the wire to check high times and bit order independently.
    always @(posedge clk) begin
        if (swp_if_i.s1_line === 1'b1) hi <= hi + 8'h01;
        else if (hi != 8'h00) begin
            hi <= 8'h00;
            if (swp_if_i.s1_oe === 1'b1) begin
                `TB_CHK(hi, hi_exp(hi > 8'h0A))
                sh <= {sh[6:0], hi > 8'h0A};
                if ({sh[6:0], hi > 8'h0A} == 8'hC1) seen <= 1'b1;
            end
        end
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // A hang is cut short well past the expected half millisecond.
    initial begin
        #2000000;
        n_fail++;
        report_and_stop();
    end

    // Both directions at once, then stall to overrun, release the contact, drain.
    initial begin
        void'($urandom(17));
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        for (int i = 0; i < N; i++) begin
            exp_s.push_back(pick(i));
            exp_m.push_back(pick(N - 1 - i));
        end
        fork
            foreach (exp_s[i]) m_send(exp_s[i]);
            foreach (exp_m[i]) s_send(exp_m[i]);
        join
        for (int i = 0; i < 4000 && (got_s.size() < N || got_m.size() < N); i++) @(posedge clk);
        `TB_CHK(got_s.size(), N)
        foreach (exp_s[i]) `TB_CHK(got_s[i], exp_s[i])
        `TB_CHK(got_m.size(), N)
        foreach (exp_m[i]) `TB_CHK(got_m[i], exp_m[i])
        `TB_CHK(seen, 1'b1)
        mode <= 2'h1;
        repeat (1800) @(posedge clk);
        `TB_CHK(s_ovr, 1'b1)
        `TB_CHK(s_rxv, 1'b1)
        dis <= 1'b1;
        repeat (20) @(posedge clk);
        `TB_CHK(swp_if_i.s1_oe, 1'b0)
        repeat (200) @(posedge clk);
        `TB_CHK(swp_if_i.s2_load, 1'b0)
        p0 = pops;
        mode <= 2'h2;
        for (int i = 0; i < 100 && (i < 3 || s_rxv === 1'b1); i++) @(posedge clk);
        `TB_CHK(pops - p0, 9)
        `TB_CHK(s_rxv, 1'b0)
        report_and_stop();
    end
endmodule // tb
